// ===== rtl/cdm_pkg.sv
// package for the clock divider and monitor register bank
// assumes a byte-wide register port driven by the serial host port logic
package cdm_pkg;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] FEEDBACK_DIV_LOW_BYTE_OFS = 8'h2a;
    localparam logic [7:0] INPUT1_DIV_UPPER_BITS_OFS = 8'h2b;
    localparam logic [7:0] INPUT1_DIV_MID_BYTE_OFS   = 8'h2c;
    localparam logic [7:0] INPUT1_DIV_LOW_BYTE_OFS   = 8'h2d;
    localparam logic [7:0] INPUT2_DIV_UPPER_BITS_OFS = 8'h2e;
    localparam logic [7:0] INPUT2_DIV_MID_BYTE_OFS   = 8'h2f;
    localparam logic [7:0] INPUT2_DIV_LOW_BYTE_OFS   = 8'h30;
    localparam logic [7:0] INPUT_RATE_BAND_SELECT_OFS = 8'h37;
    localparam logic [7:0] ACTIVE_INPUT_STATUS_OFS   = 8'h80;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] FEEDBACK_DIV_LOW_RST = 8'hf9;
    localparam logic [7:0] INPUT1_UPPER_RST     = 8'h00;
    localparam logic [7:0] INPUT1_MID_RST       = 8'h00;
    localparam logic [7:0] INPUT1_LOW_RST       = 8'h09;
    localparam logic [7:0] INPUT2_UPPER_RST     = 8'h00;
    localparam logic [7:0] INPUT2_MID_RST       = 8'h00;
    localparam logic [7:0] INPUT2_LOW_RST       = 8'h00;
    localparam logic [7:0] RATE_BAND_RST        = 8'h00;

    // ----------------------------------------------------------------
    // field layout
    // ----------------------------------------------------------------
    localparam int PREDIV_W       = 19;
    localparam int RATIO_W        = 20;
    localparam int UPPER_MSB      = 2;
    localparam int BAND_W         = 3;
    localparam int BAND1_LSB      = 0;
    localparam int BAND2_LSB      = 3;
    localparam int FIRST_ACT_BIT  = 0;
    localparam int SECOND_ACT_BIT = 1;

    // frequency band codes for offset-alarm monitoring
    typedef enum logic [2:0] {
        CDM_BAND_10_27   = 3'b000,
        CDM_BAND_25_54   = 3'b001,
        CDM_BAND_50_105  = 3'b010,
        CDM_BAND_95_215  = 3'b011,
        CDM_BAND_190_435 = 3'b100,
        CDM_BAND_375_710 = 3'b101,
        CDM_BAND_RSV6    = 3'b110,
        CDM_BAND_RSV7    = 3'b111
    } cdm_band_t;

    // per-input divider and monitor settings
    typedef struct packed {
        logic [PREDIV_W-1:0] divCode;
        logic [RATIO_W-1:0]  divRatio;
        cdm_band_t           rateBand;
        logic                rateBandValid;
    } cdm_input_cfg_t;
endpackage

// ===== rtl/cdm_regs.sv
// register bank for feedback divider, input pre-dividers, rate bands and active-input status
// assumes a byte-wide register port from the serial host port, synchronous to ref_clk
//
// Behaviour
// - the low feedback divider byte drives the phase detector divider low byte and resets to 0xf9.
// - the first input is divided by a 19-bit code built from bits 2:0 of one register and two byte registers.
// - each input divider code divides by code plus one, from one up to two to the nineteenth.
// - the second input is divided by its own 19-bit code laid out the same way.
// - each input has a three-bit band code for offset monitoring and codes 110 and 111 are reserved.
// - status bit 1 is high only while the second input is selected and has no signal loss.
// - status bit 0 is high only while the first input is selected and has no signal loss.
// - each input's signal loss alarm reads 1 while loss is detected and 0 otherwise.
`timescale 1ns/1ns
module cdm_regs
    import cdm_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           nrst,
    input  wire logic [7:0]     regAddr,
    input  wire logic           regWrEn,
    input  wire logic           regRdEn,
    input  wire logic [7:0]     regWrData,
    output logic      [7:0]     regRdData,
    output logic                regRdValid,
    input  wire logic           firstInputSelected,
    input  wire logic           secondInputSelected,
    input  wire logic           firstInputLossDetect,
    input  wire logic           secondInputLossDetect,
    output logic      [7:0]     feedbackLowSpeedDividerLow,
    output cdm_input_cfg_t      firstInputCfg,
    output cdm_input_cfg_t      secondInputCfg,
    output logic                firstInputActiveFlag,
    output logic                secondInputActiveFlag,
    output logic                firstInputSignalLossAlarm,
    output logic                secondInputSignalLossAlarm
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [7:0] feedbackDiv_reg;
    logic [2:0] firstUpper_reg;
    logic [7:0] firstMid_reg;
    logic [7:0] firstLow_reg;
    logic [2:0] secondUpper_reg;
    logic [7:0] secondMid_reg;
    logic [7:0] secondLow_reg;
    logic [5:0] rateBand_reg;
    logic [1:0] status_reg;
    logic [1:0] lossAlarm_reg;
    logic [7:0] rdData_next;

    // write strobe for one offset
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs, input logic en);
        hit = en && (addr == ofs);
    endfunction

    // band code in the usable range
    function automatic logic bandOk(input logic [2:0] code);
        bandOk = (code <= CDM_BAND_375_710);
    endfunction

    // ----------------------------------------------------------------
    // feedback divider byte
    // ----------------------------------------------------------------
    // low byte of the phase detector divider
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            feedbackDiv_reg <= FEEDBACK_DIV_LOW_RST;
        end else if (hit(regAddr, FEEDBACK_DIV_LOW_BYTE_OFS, regWrEn)) begin
            feedbackDiv_reg <= regWrData;
        end
    end

    // ----------------------------------------------------------------
    // input pre-dividers
    // ----------------------------------------------------------------
    // first input divider bytes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            firstUpper_reg <= INPUT1_UPPER_RST[UPPER_MSB:0];
            firstMid_reg   <= INPUT1_MID_RST;
            firstLow_reg   <= INPUT1_LOW_RST;
        end else begin
            if (hit(regAddr, INPUT1_DIV_UPPER_BITS_OFS, regWrEn)) begin
                firstUpper_reg <= regWrData[UPPER_MSB:0];
            end
            if (hit(regAddr, INPUT1_DIV_MID_BYTE_OFS, regWrEn)) begin
                firstMid_reg <= regWrData;
            end
            if (hit(regAddr, INPUT1_DIV_LOW_BYTE_OFS, regWrEn)) begin
                firstLow_reg <= regWrData;
            end
        end
    end

    // second input divider bytes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            secondUpper_reg <= INPUT2_UPPER_RST[UPPER_MSB:0];
            secondMid_reg   <= INPUT2_MID_RST;
            secondLow_reg   <= INPUT2_LOW_RST;
        end else begin
            if (hit(regAddr, INPUT2_DIV_UPPER_BITS_OFS, regWrEn)) begin
                secondUpper_reg <= regWrData[UPPER_MSB:0];
            end
            if (hit(regAddr, INPUT2_DIV_MID_BYTE_OFS, regWrEn)) begin
                secondMid_reg <= regWrData;
            end
            if (hit(regAddr, INPUT2_DIV_LOW_BYTE_OFS, regWrEn)) begin
                secondLow_reg <= regWrData;
            end
        end
    end

    // rate band fields, top two bits are not stored
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            rateBand_reg <= RATE_BAND_RST[5:0];
        end else if (hit(regAddr, INPUT_RATE_BAND_SELECT_OFS, regWrEn)) begin
            rateBand_reg <= regWrData[5:0];
        end
    end

    // ----------------------------------------------------------------
    // status and alarms
    // ----------------------------------------------------------------
    // active input flags, never written by software
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            status_reg <= 2'h0;
        end else begin
            status_reg[FIRST_ACT_BIT]  <= firstInputSelected && !firstInputLossDetect;
            status_reg[SECOND_ACT_BIT] <= secondInputSelected && !secondInputLossDetect;
        end
    end

    // signal loss alarms follow the detectors
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            lossAlarm_reg <= 2'h0;
        end else begin
            lossAlarm_reg <= {secondInputLossDetect, firstInputLossDetect};
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // divider codes, ratios and bands
    always_comb begin
        firstInputCfg.divCode        = {firstUpper_reg, firstMid_reg, firstLow_reg};
        firstInputCfg.divRatio       = {1'b0, firstInputCfg.divCode} + 20'h00001;
        firstInputCfg.rateBand       = cdm_band_t'(rateBand_reg[BAND1_LSB +: BAND_W]);
        firstInputCfg.rateBandValid  = bandOk(rateBand_reg[BAND1_LSB +: BAND_W]);
        secondInputCfg.divCode       = {secondUpper_reg, secondMid_reg, secondLow_reg};
        secondInputCfg.divRatio      = {1'b0, secondInputCfg.divCode} + 20'h00001;
        secondInputCfg.rateBand      = cdm_band_t'(rateBand_reg[BAND2_LSB +: BAND_W]);
        secondInputCfg.rateBandValid = bandOk(rateBand_reg[BAND2_LSB +: BAND_W]);
    end

    assign feedbackLowSpeedDividerLow = feedbackDiv_reg;
    assign firstInputActiveFlag       = status_reg[FIRST_ACT_BIT];
    assign secondInputActiveFlag      = status_reg[SECOND_ACT_BIT];
    assign firstInputSignalLossAlarm  = lossAlarm_reg[0];
    assign secondInputSignalLossAlarm = lossAlarm_reg[1];

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // read mux, reserved bits and unmapped offsets give zero
    always_comb begin
        unique case (regAddr)
            FEEDBACK_DIV_LOW_BYTE_OFS:  rdData_next = feedbackDiv_reg;
            INPUT1_DIV_UPPER_BITS_OFS:  rdData_next = {5'h00, firstUpper_reg};
            INPUT1_DIV_MID_BYTE_OFS:    rdData_next = firstMid_reg;
            INPUT1_DIV_LOW_BYTE_OFS:    rdData_next = firstLow_reg;
            INPUT2_DIV_UPPER_BITS_OFS:  rdData_next = {5'h00, secondUpper_reg};
            INPUT2_DIV_MID_BYTE_OFS:    rdData_next = secondMid_reg;
            INPUT2_DIV_LOW_BYTE_OFS:    rdData_next = secondLow_reg;
            INPUT_RATE_BAND_SELECT_OFS: rdData_next = {2'h0, rateBand_reg};
            ACTIVE_INPUT_STATUS_OFS:    rdData_next = {6'h00, status_reg};
            default:                    rdData_next = 8'h00;
        endcase
    end

    // registered read data, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            regRdData  <= 8'h00;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= rdData_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    a_fb_byte_write: assert property (
        regWrEn && regAddr == FEEDBACK_DIV_LOW_BYTE_OFS |=> feedbackLowSpeedDividerLow == $past(regWrData))
        else $error("feedback byte not written");
    a_first_upper_write: assert property (
        regWrEn && regAddr == INPUT1_DIV_UPPER_BITS_OFS |=> firstInputCfg.divCode[18:16] == $past(regWrData[2:0]))
        else $error("first divider upper bits wrong");
    a_div_ratio_map: assert property (
        firstInputCfg.divRatio - 20'h00001 == {1'b0, firstUpper_reg, firstMid_reg, firstLow_reg}
        && secondInputCfg.divRatio - 20'h00001 == {1'b0, secondUpper_reg, secondMid_reg, secondLow_reg})
        else $error("divide ratio not code plus one");
    a_second_mid_write: assert property (
        regWrEn && regAddr == INPUT2_DIV_MID_BYTE_OFS |=> secondInputCfg.divCode[15:8] == $past(regWrData))
        else $error("second divider mid byte wrong");
    a_band_reserved_flag: assert property (
        regWrEn && regAddr == INPUT_RATE_BAND_SELECT_OFS && regWrData[2:1] == 2'h3
        |=> !firstInputCfg.rateBandValid)
        else $error("reserved band code flagged valid");
    a_second_active_flag: assert property (
        ##1 secondInputActiveFlag == ($past(secondInputSelected) && !$past(secondInputLossDetect)))
        else $error("second active flag wrong");
    a_first_active_read: assert property (
        regRdEn && regAddr == ACTIVE_INPUT_STATUS_OFS |=> regRdValid && regRdData[0] == $past(firstInputActiveFlag))
        else $error("first active flag read wrong");
    a_loss_alarm_follow: assert property (
        firstInputLossDetect ##1 firstInputLossDetect |-> firstInputSignalLossAlarm ##1 firstInputSignalLossAlarm)
        else $error("loss alarm not following detector");
    a_reserved_read_zero: assert property (
        regRdEn && regAddr == INPUT2_DIV_UPPER_BITS_OFS |=> regRdData[7:3] == 5'h00)
        else $error("reserved bits read nonzero");

    c_first_active: cover property (firstInputSelected && !firstInputLossDetect ##1 firstInputActiveFlag);
    c_loss_drops_active: cover property (secondInputActiveFlag ##1 secondInputLossDetect ##1 !secondInputActiveFlag);
    c_reserved_band: cover property (!secondInputCfg.rateBandValid);
    c_status_read: cover property (regRdEn && regAddr == ACTIVE_INPUT_STATUS_OFS ##1 regRdValid);
endmodule

// ===== test/cdm_regs_test.sv
// self-checking testbench for the clock divider and monitor register bank
// assumes the byte-wide strobe register port and one 50 MHz clock with synchronous active-low reset
`timescale 1ns/1ns
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end
module cdm_regs_test;
    import cdm_pkg::*;
    logic           ref_clk;
    logic           nrst;
    logic [7:0]     regAddr;
    logic           regWrEn;
    logic           regRdEn;
    logic [7:0]     regWrData;
    logic [7:0]     regRdData;
    logic           regRdValid;
    logic           sel1, sel2, los1, los2;
    logic [7:0]     fbLow;
    cdm_input_cfg_t cfg1, cfg2;
    logic           act1, act2, alm1, alm2;
    int             err_total, checked, cycles;

    cdm_regs dut (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
        .firstInputSelected(sel1), .secondInputSelected(sel2), .firstInputLossDetect(los1),
        .secondInputLossDetect(los2), .feedbackLowSpeedDividerLow(fbLow), .firstInputCfg(cfg1),
        .secondInputCfg(cfg2), .firstInputActiveFlag(act1), .secondInputActiveFlag(act2),
        .firstInputSignalLossAlarm(alm1), .secondInputSignalLossAlarm(alm2));

    // ----------------------------------------------------------------
    // clock, hang guard and closing report
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // cut a hang short well past the expected run length
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // register port cycles
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) begin regWrEn <= 1'b1; regAddr <= a; regWrData <= d; end
        @(posedge ref_clk) regWrEn <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk) begin regRdEn <= 1'b1; regAddr <= a; end
        @(posedge ref_clk) regRdEn <= 1'b0;
        #1 d = regRdData;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // reset values of every register, of the feedback output and of the first input's divider code and ratio
    task automatic t_reset();
        logic [7:0] ofs [9] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h37, 8'h80};
        logic [7:0] rst [9] = '{8'hf9, 8'h00, 8'h00, 8'h09, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 9; i++) begin
            rd(ofs[i], d);
            `CHK(d, rst[i])
        end
        `CHK(fbLow, 8'hf9)
        `CHK(cfg1.divCode, 19'h00009)
        `CHK(cfg1.divRatio, 20'h0000a)
    endtask
    // feedback low byte follows writes; unmapped places ignore writes and read zero
    task automatic t_feedback();
        logic [7:0] d;
        wr(8'h2a, 8'h55);
        `CHK(fbLow, 8'h55)
        wr(8'h31, 8'haa);
        rd(8'h2a, d);
        `CHK(d, 8'h55)
        `CHK(regRdValid, 1'b1)
        @(posedge ref_clk);
        #1;
        `CHK(regRdValid, 1'b0)
        rd(8'h31, d);
        `CHK(d, 8'h00)
    endtask
    // first pre-divider at both end codes, reserved upper bits dropped
    task automatic t_div1();
        logic [7:0] d;
        wr(8'h2b, 8'hff);
        wr(8'h2c, 8'hff);
        wr(8'h2d, 8'hff);
        `CHK(cfg1.divCode, 19'h7ffff)
        `CHK(cfg1.divRatio, 20'h80000)
        `CHK(cfg2.divCode, 19'h00000)
        rd(8'h2b, d);
        `CHK(d, 8'h07)
        wr(8'h2b, 8'h00);
        wr(8'h2c, 8'h00);
        wr(8'h2d, 8'h00);
        `CHK(cfg1.divRatio, 20'h00001)
    endtask
    // second pre-divider with a mixed pattern, first one untouched
    task automatic t_div2();
        logic [7:0] d;
        wr(8'h2e, 8'hfd);
        wr(8'h2f, 8'ha3);
        wr(8'h30, 8'h3c);
        `CHK(cfg2.divCode, 19'h5a33c)
        `CHK(cfg2.divRatio, 20'h5a33d)
        `CHK(cfg1.divCode, 19'h00000)
        rd(8'h2e, d);
        `CHK(d, 8'h05)
        rd(8'h30, d);
        `CHK(d, 8'h3c)
    endtask
    // mid-run reset brings written registers back to their reset values
    task automatic t_rereset();
        wr(8'h2a, 8'h12);
        @(posedge ref_clk) nrst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'b1;
        #1;
        `CHK(fbLow, 8'hf9)
        `CHK(cfg2.divCode, 19'h00000)
    endtask
    // every band code on both inputs, reserved codes flagged
    task automatic t_band();
        logic [7:0] d;
        logic [2:0] c;
        for (int i = 0; i < 8; i++) begin
            c = 3'(i);
            wr(8'h37, {2'h3, c, ~c});
            `CHK(cfg2.rateBand, cdm_band_t'(c))
            `CHK(cfg1.rateBand, cdm_band_t'(~c))
            `CHK(cfg2.rateBandValid, (c <= 3'h5))
            `CHK(cfg1.rateBandValid, (~c <= 3'h5))
            rd(8'h37, d);
            `CHK(d, {2'h0, c, ~c})
        end
    endtask
    // selection and loss combinations on both inputs, status readback and write immunity
    task automatic t_status();
        logic [7:0] d;
        logic       s, l;
        for (int i = 0; i < 4; i++) begin
            s = i[1];
            l = i[0];
            @(posedge ref_clk) begin sel1 <= s; los1 <= l; sel2 <= ~s; los2 <= ~l; end
            @(posedge ref_clk);
            #1;
            `CHK(act1, s & ~l)
            `CHK(act2, ~s & l)
            `CHK(alm1, l)
            `CHK(alm2, ~l)
            wr(8'h80, 8'hff);
            rd(8'h80, d);
            `CHK(d, {6'h00, ~s & l, s & ~l})
        end
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        regAddr = 8'h00;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regWrData = 8'h00;
        sel1 = 1'b0;
        sel2 = 1'b0;
        los1 = 1'b0;
        los2 = 1'b0;
        repeat (12) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset();
        t_feedback();
        t_div1();
        t_div2();
        t_rereset();
        t_band();
        t_status();
        wrap_up();
    end
endmodule
